// [dv/pst_host_model.sv]
// bus host model: drives the two-wire lines through open-drain pulls
`timescale 1ns/1ns
module pst_host_model
#(
    parameter int HALF_NS = 1000
)
(
    input wire logic clock,
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    // released lines float up to the pull-up level
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // release the clock and wait while the target stretches it, bounded
    task automatic rise();
        int n;
        scl_pull = 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 40000)
        begin
            @(negedge clock);
            n++;
        end
    endtask : rise
    // data changes mid-low so it never races the clock edge
    task automatic bit_io(input logic b, output logic r);
        #(HALF_NS / 2);
        sda_pull = !b;
        #(HALF_NS / 2);
        rise();
        #(HALF_NS);
        r = sda;
        scl_pull = 1'b1;
    endtask : bit_io
    // also serves as repeated start from a low clock
    task automatic start();
        #(HALF_NS / 2);
        sda_pull = 1'b0;
        #(HALF_NS / 2);
        rise();
        #(HALF_NS);
        sda_pull = 1'b1;
        #(HALF_NS);
        scl_pull = 1'b1;
    endtask : start
    task automatic stop();
        #(HALF_NS / 2);
        sda_pull = 1'b1;
        #(HALF_NS / 2);
        rise();
        #(HALF_NS);
        sda_pull = 1'b0;
        #(HALF_NS);
    endtask : stop
    // msb first, ninth bit is the acknowledge
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr
    task automatic rd(input logic last, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, q[i]);
        bit_io(last, r);
    endtask : rd
    // one-clock high pulse, shorter than the input filter accepts
    task automatic runt();
        scl_pull = 1'b0;
        #50;
        scl_pull = 1'b1;
    endtask : runt
endmodule : pst_host_model

// [dv/pst_target_test.sv]
// self-checking bench for the two-wire target
`timescale 1ns/1ns
module pst_target_test;
    import pst_pkg::*;
    logic clock, reset_n, hi, lo, scl_oe, sda_oe, hscl, hsda, k;
    logic [7:0] q;
    int bad_count = 0;
    int comparisons = 0;
    wire logic scl = !(scl_oe | hscl);
    wire logic sda = !(sda_oe | hsda);
    //==================================================================
    // design and host
    pst_target #(.TIMEOUT_CYCLES(2000), .HOLDOFF_CYCLES(500), .STRETCH_CYCLES(1500)) uut (
        .clock(clock), .reset_n(reset_n), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_strap_hi(hi), .addr_strap_lo(lo));
    pst_host_model host (.clock(clock), .scl(scl), .sda(sda), .scl_pull(hscl), .sda_pull(hsda));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    //==================================================================
    // helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // straps settle well before the next start; filter needs four clocks
    task automatic strap(input logic [1:0] s);
        @(negedge clock);
        {hi, lo} = s;
        repeat (10) @(negedge clock);
    endtask : strap
    task automatic probe(input logic [7:0] a, input logic exp);
        host.start();
        host.wr(a, k);
        // an accepted read drives data; close it with a nack before the stop
        if (a[0] && k)
        begin
            host.rd(1'b1, q);
        end
        host.stop();
        check({7'h0, k}, {7'h0, exp});
    endtask : probe
    task automatic wr3(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
        host.start();
        host.wr(a, k);
        host.wr(c, k);
        host.wr(d, k);
        check({7'h0, k}, 8'h01);
    endtask : wr3
    //==================================================================
    // scenarios
    task automatic t_addr();
        logic [2:0] t;
        for (int i = 0; i < 4; i++)
        begin
            t = {i[1:0], 1'b0};
            strap(i[1:0]);
            probe(8'hb0 | t, 1'b1);
            probe(8'ha1 | t, 1'b1);
            probe(8'hb0 | (t ^ 3'h2), 1'b0);
            probe(8'h30 | t, 1'b0);
        end
    endtask : t_addr
    task automatic t_rw();
        strap(2'h0);
        wr3(8'hb0, 8'h21, 8'ha5);
        host.wr(8'h3c, k);
        check({7'h0, k}, 8'h01);
        // command write, repeated start, then read from that command
        host.start();
        host.wr(8'hb0, k);
        host.wr(8'h21, k);
        host.start();
        host.wr(8'hb1, k);
        host.rd(1'b0, q);
        check(q, 8'ha5);
        host.rd(1'b1, q);
        check(q, 8'h3c);
        host.stop();
    endtask : t_rw
    task automatic t_fru(input logic [7:0] ofs, input logic [7:0] exp);
        host.start();
        host.wr(8'ha0, k);
        host.wr(ofs, k);
        check({7'h0, k}, 8'h01);
        host.start();
        host.wr(8'ha1, k);
        host.rd(1'b0, q);
        check(q, exp);
        host.rd(1'b1, q);
        check(q, 8'h00);
        host.stop();
    endtask : t_fru
    // host parks the clock low mid-byte; holdoff must refuse the next address
    task automatic t_tmo();
        host.start();
        host.wr(8'hb0, k);
        repeat (3) host.bit_io(1'b0, k);
        #(2020 * 50);
        check({6'h0, scl_oe, sda_oe}, 8'h00);
        probe(8'hb0, 1'b0);
        #(500 * 50);
        probe(8'hb0, 1'b1);
    endtask : t_tmo
    // runt clock and restart mid-byte, then data must still be aligned
    task automatic t_glitch();
        host.start();
        repeat (3) host.bit_io(1'b1, k);
        host.runt();
        wr3(8'hb0, 8'h22, 8'h77);
        host.start();
        host.wr(8'hb0, k);
        host.wr(8'h22, k);
        host.start();
        host.wr(8'hb1, k);
        host.rd(1'b1, q);
        check(q, 8'h77);
        repeat (2) host.bit_io(1'b0, k);
        host.stop();
        probe(8'hb0, 1'b1);
    endtask : t_glitch
    //==================================================================
    // main sequence and watchdog
    initial
    begin
        reset_n = 1'b0;
        {hi, lo} = 2'h0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        reset_n = 1'b1;
        repeat (10) @(negedge clock);
        t_addr();
        t_rw();
        t_fru(8'h10, FRU_FLAGS_VAL);
        t_fru(8'h00, FRU_HDR_VAL);
        t_tmo();
        t_glitch();
        conclude();
    end
    initial
    begin
        #3_000_000;
        bad_count++;
        conclude();
    end
endmodule : pst_target_test

// [hdl/pst_target.sv]
// two-wire management and identification target with write buffer
`timescale 1ns/1ns
module pst_target
    import pst_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int HOLDOFF_CYCLES = HOLDOFF_CYC,
    parameter int STRETCH_CYCLES = STRETCH_CYC
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo
);
    //=================================================================
    // input synchronisers and filter
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [3:0] next_filt;
    logic scl_q;
    logic sda_q;

    // runt filtering
    // a level moves only once two stages agree, so runts never count
    always_comb
    begin
        next_filt = (s2 & s3) | (filt & (s2 | s3));
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            s1 <= SYNC_RST;
            s2 <= SYNC_RST;
            s3 <= SYNC_RST;
            filt <= SYNC_RST;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            s1 <= {addr_strap_lo, addr_strap_hi, sda_in, scl_in};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            scl_q <= filt[LN_SCL];
            sda_q <= filt[LN_SDA];
        end
    end

    //=================================================================
    // bus events and address decode
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [1:0] strap;

    // edge sampling
    // 200 clocks per bit leaves wide margin over the filter delay
    assign scl = filt[LN_SCL];
    assign sda = filt[LN_SDA];
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    assign start_ev = scl & scl_q & sda_q & ~sda;
    assign stop_ev = scl & scl_q & ~sda_q & sda;
    assign strap = {filt[LN_HI], filt[LN_LO]};

    function automatic logic pst_hit(input logic [6:0] a, input logic [1:0] st,
        input logic [6:0] base);
        pst_hit = (a == (base | {5'h00, st}));
    endfunction : pst_hit

    function automatic logic [7:0] pst_fru_byte(input logic [7:0] ofs);
        unique case (ofs)
            FRU_HDR_OFS: pst_fru_byte = FRU_HDR_VAL;
            FRU_FLAGS_OFS: pst_fru_byte = FRU_FLAGS_VAL;
            default: pst_fru_byte = 8'h00;
        endcase
    endfunction : pst_fru_byte

    //=================================================================
    // write buffer and management memory
    logic [15:0] buf_mem [BUF_DEPTH];
    logic [7:0] mgmt_mem [256];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic [2:0] land;
    logic next_wp;
    logic next_rp;
    logic [1:0] next_buf_cnt;
    logic [2:0] next_land;
    logic buf_ready;
    logic buf_idle;
    logic pop;
    logic do_push;
    logic [15:0] push_d;

    // drain takes a few cycles per word, which is what forces stalls
    always_comb
    begin
        buf_ready = (buf_cnt != BUF_FULL);
        buf_idle = (buf_cnt == 2'h0);
        pop = !buf_idle && (land == LAND_LAST);
        next_land = (buf_idle || pop) ? 3'h0 : land + 3'h1;
        next_wp = do_push ? ~buf_wp : buf_wp;
        next_rp = pop ? ~buf_rp : buf_rp;
        next_buf_cnt = buf_cnt + {1'b0, do_push} - {1'b0, pop};
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            land <= 3'h0;
        end
        else
        begin
            buf_wp <= next_wp;
            buf_rp <= next_rp;
            buf_cnt <= next_buf_cnt;
            land <= next_land;
        end
    end

    // storage has no reset; contents are data, not control
    always_ff @(posedge clock)
    begin
        if (do_push)
        begin
            buf_mem[buf_wp] <= push_d;
        end
        if (pop)
        begin
            mgmt_mem[buf_mem[buf_rp][15:8]] <= buf_mem[buf_rp][7:0];
        end
    end

    //=================================================================
    // target state machine
    pst_state_e state;
    pst_state_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic sel_fru;
    logic next_sel;
    logic rd;
    logic next_rd;
    logic first;
    logic next_first;
    logic ack_ok;
    logic next_ack;
    logic sda_drv;
    logic next_sda;
    logic scl_drv;
    logic next_scl;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] next_low;
    logic [CNT_W-1:0] str_cnt;
    logic [CNT_W-1:0] next_str;
    logic [7:0] rd_byte;
    logic to_hit;
    logic ho_done;
    logic str_lim;
    logic hit_m;
    logic hit_f;

    assign rd_byte = sel_fru ? pst_fru_byte(ptr) : mgmt_mem[ptr];
    assign to_hit = (low_cnt == CNT_W'(TIMEOUT_CYCLES));
    assign ho_done = (low_cnt == CNT_W'(HOLDOFF_CYCLES - 1));
    // two short of the budget: the release cycle after a stall still holds the clock
    assign str_lim = (str_cnt >= CNT_W'(STRETCH_CYCLES - 2));
    assign hit_m = pst_hit(sh[7:1], strap, MGMT_BASE);
    assign hit_f = pst_hit(sh[7:1], strap, FRU_BASE);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_sel = sel_fru;
        next_rd = rd;
        next_first = first;
        next_ack = ack_ok;
        next_sda = sda_drv;
        next_scl = scl_drv;
        next_low = low_cnt;
        next_str = str_cnt;
        do_push = 1'b0;
        push_d = {ptr, sh};
        // clock is let go one cycle after data settles
        if (scl_drv && state != PST_STALL_W && state != PST_STALL_R)
        begin
            next_scl = 1'b0;
        end
        // every cycle the clock is held counts against the stretch budget
        if (scl_drv)
        begin
            next_str = str_cnt + CNT_ONE;
        end
        if (state == PST_HOLD)
        begin
            next_low = low_cnt + CNT_ONE;
            if (ho_done)
            begin
                next_state = PST_IDLE;
                next_low = '0;
            end
        end
        else if (to_hit)
        begin
            next_state = PST_HOLD;
            next_low = '0;
            next_sda = 1'b0;
            next_scl = 1'b0;
        end
        else
        begin
            // own stretching is bounded separately, so it is not counted
            next_low = (scl || scl_drv) ? '0 : low_cnt + CNT_ONE;
            if (start_ev)
            begin
                next_state = PST_ADDR;
                next_cnt = 3'h0;
                next_sda = 1'b0;
                next_str = '0;
            end
            else if (stop_ev)
            begin
                next_state = PST_IDLE;
                next_sda = 1'b0;
            end
            else
            begin
                unique case (state)
                    PST_IDLE:
                    begin
                        next_sda = 1'b0;
                    end
                    PST_ADDR, PST_WBYTE:
                    begin
                        if (scl_rise)
                        begin
                            next_sh = {sh[6:0], sda};
                            next_cnt = cnt + 3'h1;
                            if (cnt == 3'h7)
                            begin
                                next_state = (state == PST_ADDR) ? PST_AACK : PST_WACK;
                            end
                        end
                    end
                    PST_AACK:
                    begin
                        if (scl_rise)
                        begin
                            next_cnt = 3'h1;
                        end
                        else if (scl_fall && cnt == 3'h0)
                        begin
                            if (hit_m || hit_f)
                            begin
                                next_sda = 1'b1;
                                next_sel = hit_f;
                                next_rd = sh[0];
                                next_first = 1'b1;
                            end
                            else
                            begin
                                next_state = PST_IDLE;
                            end
                        end
                        else if (scl_fall)
                        begin
                            next_sda = 1'b0;
                            next_cnt = 3'h0;
                            next_state = PST_WBYTE;
                            if (rd)
                            begin
                                if (!sel_fru && !buf_idle && !str_lim)
                                begin
                                    next_state = PST_STALL_R;
                                    next_scl = 1'b1;
                                end
                                else
                                begin
                                    next_state = PST_RBYTE;
                                    next_sh = rd_byte;
                                    next_sda = ~rd_byte[7];
                                    next_ptr = ptr + 8'h01;
                                end
                            end
                        end
                    end
                    PST_WACK:
                    begin
                        if (scl_rise)
                        begin
                            next_cnt = 3'h1;
                        end
                        else if (scl_fall && cnt == 3'h0)
                        begin
                            next_sda = 1'b1;
                            next_first = 1'b0;
                            if (first)
                            begin
                                next_ptr = sh;
                            end
                            else if (sel_fru)
                            begin
                                next_ptr = ptr + 8'h01;
                            end
                            // full buffer holds the clock instead of losing data
                            else if (buf_ready)
                            begin
                                do_push = 1'b1;
                                next_ptr = ptr + 8'h01;
                            end
                            // stretch budget spent: drop the byte with a nack
                            else if (str_lim)
                            begin
                                next_sda = 1'b0;
                                next_ptr = ptr + 8'h01;
                            end
                            else
                            begin
                                next_sda = 1'b0;
                                next_scl = 1'b1;
                                next_state = PST_STALL_W;
                            end
                        end
                        else if (scl_fall)
                        begin
                            next_sda = 1'b0;
                            next_cnt = 3'h0;
                            next_state = PST_WBYTE;
                        end
                    end
                    PST_STALL_W:
                    begin
                        // at the stretch limit with the buffer still full the byte is dropped with a nack
                        if (buf_ready || str_lim)
                        begin
                            do_push = buf_ready;
                            next_sda = buf_ready;
                            next_ptr = ptr + 8'h01;
                            next_state = PST_WACK;
                        end
                    end
                    PST_STALL_R:
                    begin
                        if (buf_idle || str_lim)
                        begin
                            next_state = PST_RBYTE;
                            next_sh = rd_byte;
                            next_sda = ~rd_byte[7];
                            next_cnt = 3'h0;
                            next_ptr = ptr + 8'h01;
                        end
                    end
                    PST_RBYTE:
                    begin
                        if (scl_rise && cnt == 3'h7)
                        begin
                            next_state = PST_RACK;
                            next_cnt = 3'h0;
                        end
                        else if (scl_rise)
                        begin
                            next_sh = {sh[6:0], 1'b0};
                            next_cnt = cnt + 3'h1;
                        end
                        else if (scl_fall)
                        begin
                            next_sda = ~sh[7];
                        end
                    end
                    PST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            next_cnt = 3'h1;
                            next_ack = ~sda;
                        end
                        else if (scl_fall && cnt == 3'h0)
                        begin
                            next_sda = 1'b0;
                        end
                        else if (scl_fall && ack_ok)
                        begin
                            next_state = PST_RBYTE;
                            next_sh = rd_byte;
                            next_sda = ~rd_byte[7];
                            next_cnt = 3'h0;
                            next_ptr = ptr + 8'h01;
                        end
                        else if (scl_fall)
                        begin
                            next_state = PST_IDLE;
                        end
                    end
                    default:
                    begin
                        next_state = PST_IDLE;
                        next_sda = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            state <= PST_IDLE;
            cnt <= 3'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            sel_fru <= 1'b0;
            rd <= 1'b0;
            first <= 1'b0;
            ack_ok <= 1'b0;
            sda_drv <= 1'b0;
            scl_drv <= 1'b0;
            low_cnt <= '0;
            str_cnt <= '0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            ptr <= next_ptr;
            sel_fru <= next_sel;
            rd <= next_rd;
            first <= next_first;
            ack_ok <= next_ack;
            sda_drv <= next_sda;
            scl_drv <= next_scl;
            low_cnt <= next_low;
            str_cnt <= next_str;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end
    assign scl_oe = scl_drv;
    assign sda_oe = sda_drv;

    //=================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_addr_done;
        state == PST_AACK && scl_fall && cnt == 3'h0 && !to_hit;
    endsequence
    a_mgmt_addr_ack: assert property (s_addr_done and hit_m |=> sda_oe && !sel_fru)
        else $error("management address not acknowledged");
    a_fru_addr_ack: assert property (s_addr_done and hit_f |=> sda_oe && sel_fru)
        else $error("identification address not acknowledged");
    a_no_match_nak: assert property (s_addr_done and !hit_m && !hit_f
        |=> !sda_oe && state == PST_IDLE)
        else $error("foreign address acknowledged");
    a_strap_low_base: assert property (s_addr_done and strap == 2'h0 && sh[7:1] == MGMT_BASE
        |=> sda_oe && !sel_fru)
        else $error("lowest location not selected");
    a_timeout_abort: assert property (to_hit && state != PST_HOLD
        |=> state == PST_HOLD && !scl_oe && !sda_oe)
        else $error("clock low timeout did not release bus");
    a_holdoff_quiet: assert property ($rose(state == PST_HOLD)
        |-> (state == PST_HOLD && !sda_oe)[*8])
        else $error("holdoff cut short");
    a_start_resync: assert property (start_ev && state != PST_HOLD && !to_hit
        |=> state == PST_ADDR && cnt == 3'h0)
        else $error("start did not realign");
    a_stop_resync: assert property (stop_ev && state != PST_HOLD && !to_hit
        |=> state == PST_IDLE && !sda_oe)
        else $error("stop did not end transfer");
    a_stretch_bound: assert property (scl_oe |-> str_cnt < CNT_W'(STRETCH_CYCLES))
        else $error("clock stretch over limit");
    a_read_landed: assert property (state == PST_STALL_R && next_state == PST_RBYTE
        |-> buf_idle || str_lim)
        else $error("read released before write landed");
endmodule : pst_target

// [include/pst_pkg.sv]
// constants and types for the power supply two-wire target interface
//=====================================================================
package pst_pkg;
    //=================================================================
    // clock and bus timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BUS_BPS = 100_000;
    localparam int CLK_PER_BIT = CLK_HZ / BUS_BPS;
    localparam int TIMEOUT_MS = 25;
    localparam int HOLDOFF_MS = 10;
    localparam int STRETCH_MS = 25;
    // least time, rounds up
    localparam int TIMEOUT_CYC = (TIMEOUT_MS * CLK_HZ + 999) / 1000;
    localparam int HOLDOFF_CYC = (HOLDOFF_MS * CLK_HZ + 999) / 1000;
    // longest time, rounds down
    localparam int STRETCH_CYC = (STRETCH_MS * CLK_HZ) / 1000;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
    //=================================================================
    // synchroniser lanes
    localparam int LN_SCL = 0;
    localparam int LN_SDA = 1;
    localparam int LN_HI = 2;
    localparam int LN_LO = 3;
    localparam logic [3:0] SYNC_RST = 4'hf;
    //=================================================================
    // target addresses, seven bit form
    localparam logic [6:0] MGMT_BASE = 7'h58;
    localparam logic [6:0] FRU_BASE = 7'h50;
    //=================================================================
    // write buffer and landing delay
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [2:0] LAND_LAST = 3'h3;
    //=================================================================
    // identification memory contents
    localparam logic [7:0] FRU_HDR_OFS = 8'h00;
    localparam logic [7:0] FRU_HDR_VAL = 8'h01;
    localparam logic [7:0] FRU_FLAGS_OFS = 8'h10;
    localparam int FLAG_HOT_SWAP = 4;
    localparam int FLAG_AUTO_SW = 3;
    localparam int FLAG_PFC = 2;
    localparam logic [7:0] FRU_FLAGS_VAL = (8'h01 << FLAG_HOT_SWAP)
        | (8'h01 << FLAG_AUTO_SW) | (8'h01 << FLAG_PFC);
    //=================================================================
    // target states
    typedef enum logic [3:0] {
        PST_IDLE, PST_ADDR, PST_AACK, PST_WBYTE, PST_WACK,
        PST_STALL_W, PST_RBYTE, PST_RACK, PST_STALL_R, PST_HOLD
    } pst_state_e;
endpackage : pst_pkg
